// ---- src/drt_params.svh ----
// Constants for the dual reload down timer: register map, fields, timing.
// Assumes a 10 MHz system clock and an AHB-Lite word-wide register bus.
//
// Functional notes
// - Two independent channels, each an 8-bit presettable down counter.
// - Writing one to a preset bit loads the counter from its reload value.
// - Run bit one counts, zero stops; count value held and resumed.
// - One readback read returns both count halves together; nothing is latched.
// - On underflow a channel reloads and keeps counting down.
// - Underflow drives interrupt flag, clock-out toggle and serial clock.
// - Channel 0 mode select zero (reset) counts its prescaler output.
// - Channel 1 counts only prescaled clock; no event mode.
// - Channel 0 mode select one counts edges of the event pin.
// - In event mode channel 0 ignores ratio and source clock select.
// - Edge polarity zero counts falling edges, one counts rising edges.
// - Noise reject accepts a pin change at second 2048 Hz strobe fall.
// - Source select zero picks low-speed, one high-speed oscillator.
// - Ratio codes 00,01,10,11 divide source by 1,4,32,256.
// - Prescaler runs and produces count clocks only while run bit is one.
// - Underflow sets the flag regardless of mask; mask gates request.
// - Clock-out toggles on each underflow of channel picked by select.
// - Output enable one drives clock-out on pin; zero holds pin high.
// - Enable gating is asynchronous; a half-cycle glitch may appear.
// - Serial clock is channel 1 underflows halved, whenever it runs.
`ifndef DRT_PARAMS_SVH
`define DRT_PARAMS_SVH

`define DRT_AW          4
`define DRT_OFF_CTRL    4'h0
`define DRT_OFF_CFG     4'h4
`define DRT_OFF_CNT0    4'h8
`define DRT_OFF_CNT1    4'hc
// Control register
`define DRT_B_RUN0      0
`define DRT_B_RUN1      1
`define DRT_B_PRE0      2
`define DRT_B_PRE1      3
`define DRT_B_MODE0     4
`define DRT_B_POL       5
`define DRT_B_NREJ      6
`define DRT_B_OUTSEL    7
`define DRT_B_OUTEN     8
`define DRT_B_MSK0      9
`define DRT_B_MSK1      10
`define DRT_B_FLG0      11
`define DRT_B_FLG1      12
`define DRT_B_CKS0      13
`define DRT_B_CKS1      14
`define DRT_B_PS0       15
`define DRT_B_PS1       17
// Config register: reload values
`define DRT_B_RLD0      0
`define DRT_B_RLD1      8
// Readback register: low count half at bit 0, live high count half at bit 8
`define DRT_B_RB_HI     8
// Prescaler taps
`define DRT_PS_W        8
`define DRT_TAP4        1
`define DRT_TAP32       4
`define DRT_TAP256      7
// Noise rejector strobe
`define DRT_CLK_HZ      10000000
`define DRT_STB_HZ      4096
`define DRT_STB_CYC     (`DRT_CLK_HZ / `DRT_STB_HZ)
`define DRT_STB_W       12
// Strobe falls counted before the one that accepts a change
`define DRT_NREJ_LAST   2'h1
`define DRT_CMD_W       19
`endif

// ---- src/drt_pkg.sv ----
// Types for the dual reload down timer.
// Assumes drt_params.svh is on the include path.
package drt_pkg;
   typedef struct packed {
      logic [1:0] ratio;
      logic       src_sel;
      logic       run;
   } drt_chcfg_t;

   typedef struct packed {
      logic       irq;
      logic       pin_level;
      logic       clock_out_signal;
      logic       serial_clock;
   } drt_out_t;
endpackage

// ---- src/drt_top.sv ----
// Dual 8-bit reload down timer with AHB-Lite register slave.
// Assumes oscillator inputs are clock-enable style levels synchronous to
// clock_i, and a single-slave AHB-Lite bus with word transfers.
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "drt_params.svh"

module drt_top
#(
   parameter int CNT_W = 8
)
(
   // Clock and reset
   input  wire logic           clock_i,
   input  wire logic           nrst_i,
   // AHB-Lite slave
   input  wire logic           hsel_i,
   input  wire logic [31:0]    haddr_i,
   input  wire logic [1:0]     htrans_i,
   input  wire logic           hwrite_i,
   input  wire logic [2:0]     hsize_i,
   input  wire logic [31:0]    hwdata_i,
   input  wire logic           hready_i,
   output logic      [31:0]    hrdata_o,
   output logic                hreadyout_o,
   output logic                hresp_o,
   // Oscillator sources
   input  wire logic           low_speed_oscillator_i,
   input  wire logic           high_speed_oscillator_i,
   // Event pin
   input  wire logic           event_input_pin_i,
   // Outputs
   output drt_pkg::drt_out_t   out_o
);
   import drt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic                  wr_pend_q;
   logic [`DRT_AW-1:0]    addr_q;
   logic                  ctrl_wr;
   logic                  cfg_wr;
   logic                  acc;

   assign acc = hsel_i && hready_i && htrans_i[1];
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         wr_pend_q <= 1'b0;
         addr_q    <= '0;
      end
      else
      begin
         wr_pend_q <= acc && hwrite_i;
         if (acc)
            addr_q <= haddr_i[`DRT_AW-1:0];
      end
   end

   assign ctrl_wr = wr_pend_q && (addr_q == `DRT_OFF_CTRL);
   assign cfg_wr  = wr_pend_q && (addr_q == `DRT_OFF_CFG);

   ////////////////////////////////////////////////////////////////////////
   // Control and configuration registers
   logic [CNT_W-1:0] rld_q [2];
   drt_chcfg_t       chcfg_q [2];
   logic             mode0_q;
   logic             pol_q;
   logic             nrej_q;
   logic             osel_q;
   logic             outen_q;
   logic [1:0]       msk_q;
   logic [1:0]       flg_q;
   logic [1:0]       preset;
   logic [1:0]       unf;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         mode0_q <= 1'b0;
         pol_q   <= 1'b0;
         nrej_q  <= 1'b0;
         osel_q  <= 1'b0;
         outen_q <= 1'b0;
         msk_q   <= 2'h0;
      end
      else if (ctrl_wr)
      begin
         mode0_q <= hwdata_i[`DRT_B_MODE0];
         pol_q   <= hwdata_i[`DRT_B_POL];
         nrej_q  <= hwdata_i[`DRT_B_NREJ];
         osel_q  <= hwdata_i[`DRT_B_OUTSEL];
         outen_q <= hwdata_i[`DRT_B_OUTEN];
         msk_q   <= {hwdata_i[`DRT_B_MSK1], hwdata_i[`DRT_B_MSK0]};
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         chcfg_q[0] <= '0;
         chcfg_q[1] <= '0;
      end
      else if (ctrl_wr)
      begin
         chcfg_q[0] <= '{ratio:   hwdata_i[`DRT_B_PS0+:2],
                         src_sel: hwdata_i[`DRT_B_CKS0],
                         run:     hwdata_i[`DRT_B_RUN0]};
         chcfg_q[1] <= '{ratio:   hwdata_i[`DRT_B_PS1+:2],
                         src_sel: hwdata_i[`DRT_B_CKS1],
                         run:     hwdata_i[`DRT_B_RUN1]};
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         rld_q[0] <= '0;
         rld_q[1] <= '0;
      end
      else if (cfg_wr)
      begin
         rld_q[0] <= hwdata_i[`DRT_B_RLD0+:CNT_W];
         rld_q[1] <= hwdata_i[`DRT_B_RLD1+:CNT_W];
      end
   end

   assign preset[0] = ctrl_wr && hwdata_i[`DRT_B_PRE0];
   assign preset[1] = ctrl_wr && hwdata_i[`DRT_B_PRE1];

   // Flags: set by underflow wins over write-one clear
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         flg_q <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (unf[i])
               flg_q[i] <= 1'b1;
            else if (ctrl_wr && hwdata_i[`DRT_B_FLG0 + i])
               flg_q[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event pin: synchroniser, noise rejector, edge detect
   logic        ev_s1_q;
   logic        ev_s2_q;
   logic        ev_flt_q;
   logic        ev_prev_q;
   logic [1:0]  stb_cnt_q;
   logic [`DRT_STB_W-1:0] stb_div_q;
   logic        stb_q;
   logic        stb_fall;
   logic        ev_lvl;
   logic        ev_edge;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         ev_s1_q <= 1'b0;
         ev_s2_q <= 1'b0;
      end
      else
      begin
         ev_s1_q <= event_input_pin_i;
         ev_s2_q <= ev_s1_q;
      end
   end

   // 2048 Hz strobe: toggles at twice that rate
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         stb_div_q <= '0;
         stb_q     <= 1'b0;
      end
      else if (stb_div_q == `DRT_STB_W'(`DRT_STB_CYC - 1))
      begin
         stb_div_q <= '0;
         stb_q     <= ~stb_q;
      end
      else
         stb_div_q <= stb_div_q + 1'b1;
   end

   assign stb_fall = stb_q &&
                     (stb_div_q == `DRT_STB_W'(`DRT_STB_CYC - 1));

   // Change must persist through two strobe falling edges
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         ev_flt_q  <= 1'b0;
         stb_cnt_q <= 2'h0;
      end
      else if (ev_s2_q == ev_flt_q)
         stb_cnt_q <= 2'h0;
      else if (stb_fall)
      begin
         if (stb_cnt_q == `DRT_NREJ_LAST)
         begin
            ev_flt_q  <= ev_s2_q;
            stb_cnt_q <= 2'h0;
         end
         else
            stb_cnt_q <= stb_cnt_q + 1'b1;
      end
   end

   assign ev_lvl = nrej_q ? ev_flt_q : ev_s2_q;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         ev_prev_q <= 1'b0;
      else
         ev_prev_q <= ev_lvl;
   end

   assign ev_edge = pol_q ? (ev_lvl && !ev_prev_q)
                          : (!ev_lvl && ev_prev_q);

   ////////////////////////////////////////////////////////////////////////
   // Channels: prescaler and down counter
   logic [CNT_W-1:0] cnt_q [2];
   logic [1:0]       tick;

   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      logic [`DRT_PS_W-1:0] ps_q;
      logic                 src_tick;
      logic                 ps_tick;
      logic                 tap;

      assign src_tick = chcfg_q[c].src_sel ? high_speed_oscillator_i
                                           : low_speed_oscillator_i;

      always_ff @(posedge clock_i)
      begin
         if (!nrst_i)
            ps_q <= '0;
         else if (chcfg_q[c].run && src_tick)
            ps_q <= ps_q + 1'b1;
      end

      always_comb
      begin
         unique case (chcfg_q[c].ratio)
            2'h0: tap = 1'b1;
            2'h1: tap = &ps_q[`DRT_TAP4:0];
            2'h2: tap = &ps_q[`DRT_TAP32:0];
            2'h3: tap = &ps_q[`DRT_TAP256:0];
         endcase
      end

      assign ps_tick = chcfg_q[c].run && src_tick && tap;

      if (c == 0)
      begin : g_ev
         assign tick[c] = mode0_q ? (chcfg_q[c].run && ev_edge) : ps_tick;
      end
      else
      begin : g_tm
         assign tick[c] = ps_tick;
      end

      assign unf[c] = tick[c] && (cnt_q[c] == '0) && !preset[c];

      always_ff @(posedge clock_i)
      begin
         if (!nrst_i)
            cnt_q[c] <= '0;
         else if (preset[c])
            cnt_q[c] <= rld_q[c];
         else if (unf[c])
            cnt_q[c] <= rld_q[c];
         else if (tick[c])
            cnt_q[c] <= cnt_q[c] - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Readback: decoded in the address phase, captured at its edge.
   // One edge takes both count halves, so no borrow can split them.
   // A read right behind a write to the same register sees old data.
   logic [31:0]      rdata;
   localparam int HALF = CNT_W / 2;

   always_comb
   begin
      rdata = '0;
      unique case (haddr_i[`DRT_AW-1:0])
         `DRT_OFF_CTRL:
         begin
            rdata[`DRT_B_RUN0]  = chcfg_q[0].run;
            rdata[`DRT_B_RUN1]  = chcfg_q[1].run;
            rdata[`DRT_B_MODE0] = mode0_q;
            rdata[`DRT_B_POL]   = pol_q;
            rdata[`DRT_B_NREJ]  = nrej_q;
            rdata[`DRT_B_OUTSEL] = osel_q;
            rdata[`DRT_B_OUTEN] = outen_q;
            rdata[`DRT_B_MSK0]  = msk_q[0];
            rdata[`DRT_B_MSK1]  = msk_q[1];
            rdata[`DRT_B_FLG0]  = flg_q[0];
            rdata[`DRT_B_FLG1]  = flg_q[1];
            rdata[`DRT_B_CKS0]  = chcfg_q[0].src_sel;
            rdata[`DRT_B_CKS1]  = chcfg_q[1].src_sel;
            rdata[`DRT_B_PS0+:2] = chcfg_q[0].ratio;
            rdata[`DRT_B_PS1+:2] = chcfg_q[1].ratio;
         end
         `DRT_OFF_CFG:
         begin
            rdata[`DRT_B_RLD0+:CNT_W] = rld_q[0];
            rdata[`DRT_B_RLD1+:CNT_W] = rld_q[1];
         end
         `DRT_OFF_CNT0:
         begin
            rdata[HALF-1:0] = cnt_q[0][HALF-1:0];
            rdata[`DRT_B_RB_HI+:HALF] = cnt_q[0][CNT_W-1:HALF];
         end
         `DRT_OFF_CNT1:
         begin
            rdata[HALF-1:0] = cnt_q[1][HALF-1:0];
            rdata[`DRT_B_RB_HI+:HALF] = cnt_q[1][CNT_W-1:HALF];
         end
         default: rdata = '0;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         hrdata_o <= '0;
      else if (acc && !hwrite_i)
         hrdata_o <= rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock-out, serial clock and interrupt
   logic cko_q;
   logic sclk_q;

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         cko_q <= 1'b0;
      else if (unf[osel_q])
         cko_q <= ~cko_q;
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         sclk_q <= 1'b0;
      else if (unf[1])
         sclk_q <= ~sclk_q;
   end

   assign out_o.clock_out_signal = cko_q;
   assign out_o.serial_clock     = sclk_q;
   // Enable gates the toggle directly, so switching may clip a half cycle
   assign out_o.pin_level = outen_q ? cko_q : 1'b1;
   assign out_o.irq = |(flg_q & msk_q);

endmodule // drt_top

// ---- tb/drt_chk_properties.sv ----
// Port checker for the dual reload down timer.
// Assumes one clock domain and a single bus slave.
`timescale 1ns/1ps
`include "drt_params.svh"
module drt_chk
(
   // Clock, reset and bus
   input wire logic        clock_i,
   input wire logic        nrst_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   // Timer outputs
   input wire drt_pkg::drt_out_t out_o
);
   import drt_pkg::*;
   logic        wr_q;
   logic [31:0] ctl_q;
   wire co = out_o.clock_out_signal;
   wire sc = out_o.serial_clock;
   wire r0 = ctl_q[`DRT_B_RUN0];
   wire r1 = ctl_q[`DRT_B_RUN1];
   wire sl = ctl_q[`DRT_B_OUTSEL];
   // Shadow copy of the control word
   always_ff @(posedge clock_i)
      if (!nrst_i)
         wr_q <= 1'b0;
      else if (hready_i)
         wr_q <= hsel_i && htrans_i[1] && hwrite_i && haddr_i[3:0] == 4'h0;
   always_ff @(posedge clock_i)
      if (!nrst_i)
         ctl_q <= 32'h0;
      else if (hready_i && wr_q)
         ctl_q <= hwdata_i;
   ////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   sequence s_halt;
      !r0 && !r1 ##1 !r0 && !r1;
   endsequence
   property p_ready; hreadyout_o; endproperty
   a_ready: assert property (p_ready) else $error("wait state");
   property p_resp; !hresp_o; endproperty
   a_resp: assert property (p_resp) else $error("error response");
   property p_reset; $rose(nrst_i) |-> out_o == 4'b0100 && !hrdata_o;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state");
   property p_pin;
      out_o.pin_level == (ctl_q[`DRT_B_OUTEN] ? co : 1'b1);
   endproperty
   a_pin: assert property (p_pin) else $error("pin level");
   property p_irq;
      !ctl_q[`DRT_B_MSK0] && !ctl_q[`DRT_B_MSK1] |-> !out_o.irq;
   endproperty
   a_irq: assert property (p_irq) else $error("masked irq");
   property p_stop; s_halt |-> $stable(co) && $stable(sc); endproperty
   a_stop: assert property (p_stop) else $error("stopped toggle");
   property p_ser; $changed(sc) |-> $past(r1); endproperty
   a_ser: assert property (p_ser) else $error("serial clock");
   property p_sel1; $changed(co) && $past(sl) |-> $changed(sc);
   endproperty
   a_sel1: assert property (p_sel1) else $error("clock out ch1");
   property p_sel0; $changed(co) && !$past(sl) |-> $past(r0);
   endproperty
   a_sel0: assert property (p_sel0) else $error("clock out ch0");
endmodule // drt_chk

bind drt_top drt_chk u_chk (.clock_i(clock_i), .nrst_i(nrst_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .out_o(out_o));

// ---- tb/drt_evsrc.sv ----
// External event source driving the timer's event pin.
// Assumes start_i is a one-cycle request.
`timescale 1ns/1ps
module drt_evsrc
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   // Request: n_i level changes, each held half_i cycles
   input  wire logic        start_i,
   input  wire logic [7:0]  n_i,
   input  wire logic [15:0] half_i,
   output logic             busy_o,
   // Pin
   output logic             event_o
);
   logic [7:0]  left_q;
   logic [15:0] cnt_q;
   assign busy_o = left_q != 8'h0;
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         event_o <= 1'b0;
         left_q  <= 8'h0;
         cnt_q   <= 16'h0;
      end
      else if (start_i)
      begin
         left_q <= n_i;
         cnt_q  <= half_i;
      end
      else if (busy_o && cnt_q > 16'h1)
         cnt_q <= cnt_q - 16'h1;
      else if (busy_o)
      begin
         event_o <= !event_o;
         left_q  <= left_q - 8'h1;
         cnt_q   <= half_i;
      end
   end
endmodule // drt_evsrc

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual reload down timer.
// Assumes the event source model and drt_params.svh are present.
`timescale 1ns/1ps
`include "drt_params.svh"
module tb_top;
   import drt_pkg::*;
   logic        clock = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        ls = 1'b0, hs = 1'b0, go = 1'b0, hready, evp, busy;
   logic [1:0]  htrans = 2'h0, ph = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, v;
   logic [7:0]  ev_n = 8'h0;
   logic [15:0] ev_h = 16'h0;
   drt_out_t    out;
   int          mismatches = 0, n_compared = 0, n;
   // Channel, source, ratio code, reload, cycles between toggles
   int rows [6][5] = '{'{0, 1, 0, 4, 5}, '{0, 1, 1, 2, 12},
      '{1, 1, 2, 1, 64}, '{1, 1, 3, 0, 256}, '{0, 0, 0, 3, 12},
      '{1, 0, 1, 1, 24}};

   always #50 clock = !clock;
   // High-speed source ticks each cycle, low-speed each third
   always @(posedge clock)
   begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      ls <= ph == 2'h2;
      hs <= nrst;
   end

   drt_top u_dut (.clock_i(clock), .nrst_i(nrst), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
      .low_speed_oscillator_i(ls), .high_speed_oscillator_i(hs),
      .event_input_pin_i(evp), .out_o(out));
   drt_evsrc u_src (.clock_i(clock), .nrst_i(nrst), .start_i(go),
      .n_i(ev_n), .half_i(ev_h), .busy_o(busy), .event_o(evp));
   ////////////////////
   task summarize;
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task hang;
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      summarize;
   endtask
   task cmp(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task tick;
      @(posedge clock);
      #1;
   endtask
   task ack;
      int i;
      for (i = 0; i == 0 || (hready !== 1'b1 && i < 20); i++)
         tick;
      if (hready !== 1'b1)
         hang;
   endtask
   // Single transfer; read data is taken at the edge ending the data phase
   task bus(input logic [31:0] a, d, input logic w);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      ack;
      htrans <= 2'h0;
      hwdata <= d;
      ack;
      q = hrdata;
      hsel <= 1'b0;
      tick;
   endtask
   task wr(input logic [31:0] a, d); bus(a, d, 1'b1); endtask
   task rd(input logic [31:0] a); bus(a, 32'h0, 1'b0); endtask
   function automatic logic [31:0] cnt();
      return {24'h0, q[`DRT_B_RB_HI+3:`DRT_B_RB_HI], q[3:0]};
   endfunction
   function automatic logic [31:0] cw(input int c, r, p, s, d);
      return 32'((r << (`DRT_B_RUN0 + c)) | (p << (`DRT_B_PRE0 + c))
         | (s << (`DRT_B_CKS0 + c)) | (d << (`DRT_B_PS0 + 2 * c)));
   endfunction
   task period;
      logic p;
      repeat (2)
      begin
         p = out.clock_out_signal;
         for (n = 0; n < 600 && out.clock_out_signal === p; n++)
            tick;
         if (n >= 600)
            hang;
      end
   endtask
   task pulse(input logic [7:0] c, input logic [15:0] h);
      int i;
      ev_n <= c;
      ev_h <= h;
      go <= 1'b1;
      tick;
      go <= 1'b0;
      for (i = 0; i < 30000 && busy === 1'b1; i++)
         tick;
      if (busy !== 1'b0)
         hang;
      else
         repeat (8) tick;
   endtask
   ////////////////////
   initial
   begin
      repeat (16) @(posedge clock);
      nrst <= 1'b1;
      tick;
      for (int a = 0; a < 16; a += 4)
      begin
         rd(32'(a));
         cmp(q, 32'h0);
      end
      foreach (rows[k])
      begin
         wr(`DRT_OFF_CFG, 32'(rows[k][3] << (8 * rows[k][0])));
         wr(`DRT_OFF_CTRL, cw(rows[k][0], 1, 1, rows[k][1], rows[k][2])
            | 32'((rows[k][0] << `DRT_B_OUTSEL) | (1 << `DRT_B_OUTEN)));
         period;
         cmp(32'(n), 32'(rows[k][4]));
         cmp(32'(out.pin_level), 32'(out.clock_out_signal));
      end
      wr(`DRT_OFF_CTRL, 32'h0);
      cmp(32'(out.pin_level), 32'h1);
      rd(`DRT_OFF_CTRL);
      cmp(32'(q[`DRT_B_FLG1]), 32'h1);
      cmp(32'(out.irq), 32'h0);
      wr(`DRT_OFF_CTRL, 32'h1 << `DRT_B_MSK1);
      cmp(32'(out.irq), 32'h1);
      wr(`DRT_OFF_CTRL, 32'h1 << `DRT_B_MSK1 | 32'h1 << `DRT_B_FLG1);
      cmp(32'(out.irq), 32'h0);
      wr(`DRT_OFF_CFG, 32'h37);
      wr(`DRT_OFF_CTRL, cw(0, 0, 1, 0, 1));
      rd(`DRT_OFF_CNT0);
      cmp(cnt(), 32'h37);
      for (int k = 0; k < 2; k++)
      begin
         v = cnt();
         wr(`DRT_OFF_CTRL, cw(0, 1, 0, 0, 1));
         repeat (40) tick;
         wr(`DRT_OFF_CTRL, 32'h0);
         rd(`DRT_OFF_CNT0);
         cmp(32'(cnt() < v), 32'h1);
         v = cnt();
         repeat (30) tick;
         rd(`DRT_OFF_CNT0);
         cmp(cnt(), v);
      end
      wr(`DRT_OFF_CFG, 32'h40);
      wr(`DRT_OFF_CTRL, cw(0, 1, 1, 1, 0) | 32'h1 << `DRT_B_MODE0);
      pulse(8'h3, 16'd10);
      rd(`DRT_OFF_CNT0);
      cmp(cnt(), 32'h3f);
      wr(`DRT_OFF_CTRL, cw(0, 1, 0, 1, 0) | 32'h1 << `DRT_B_MODE0
         | 32'h1 << `DRT_B_POL);
      pulse(8'h5, 16'd10);
      rd(`DRT_OFF_CNT0);
      cmp(cnt(), 32'h3d);
      wr(`DRT_OFF_CTRL, cw(0, 1, 0, 1, 0) | 32'h1 << `DRT_B_MODE0
         | 32'h1 << `DRT_B_NREJ);
      pulse(8'h2, 16'd2000);
      pulse(8'h2, 16'd12000);
      repeat (12000) tick;
      rd(`DRT_OFF_CNT0);
      cmp(cnt(), 32'h3c);
      // Reset in mid-run clears every register again
      nrst <= 1'b0;
      repeat (2) tick;
      nrst <= 1'b1;
      tick;
      for (int a = 0; a < 16; a += 4)
      begin
         rd(32'(a));
         cmp(q, 32'h0);
      end
      cmp(32'(out.pin_level), 32'h1);
      summarize;
   end
endmodule // tb_top
